// *** hw/spb_meas.sv ***
/*
 * Measurement sequencer: triggers the sensor core, times the
 * measurement and holds the most recently completed result.
 * Assumes the sensor core runs on clk_sys_i and offers a live position.
 */
`timescale 1ns/100ps
module spb_meas
#(
    parameter int MEAS_CYC   = spb_pkg::MEAS_CYC_DEF,
    parameter int RETRIG_CYC = spb_pkg::RETRIG_CYC_DEF
)
(
    input  wire logic                         clk_sys_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         frame_start_i,
    input  wire logic [spb_pkg::RES_BITS-1:0] sensor_pos_i,
    input  wire logic                         sensor_ok_i,
    output logic                              meas_start_o,
    output logic [spb_pkg::RES_BITS-1:0]      res_pos_o,
    output logic                              res_valid_o
);
    import spb_pkg::*;

    // Allowed completion window, 90 to 95 us, for the timing check
    localparam int MEAS_LO_CYC = MEAS_TIME_US * CLK_MHZ;
    localparam int MEAS_HI_CYC = 95 * CLK_MHZ;

    logic              busy;
    logic [MEAS_W-1:0] meas_age;
    logic [MEAS_W-1:0] meas_cnt;
    logic [MEAS_W-1:0] trig_cnt;
    logic              trigger;
    logic              done;

    // ************************************************************
    // Trigger: a frame start, or the auto timer, unless busy
    // ************************************************************
    assign trigger = !busy && (frame_start_i ||
                     trig_cnt == MEAS_W'(RETRIG_CYC - 1));  // [RL11] [RL13]
    assign done    = busy && meas_cnt == MEAS_W'(MEAS_CYC - 1);

    // Measurement timer, result is ready a fixed time after trigger
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            busy     <= 1'b0;
            meas_cnt <= '0;
        end
        else if (trigger)
        begin
            busy     <= 1'b1;
            meas_cnt <= '0;
        end
        else if (done)
            busy     <= 1'b0;                               // [RL12]
        else if (busy)
            meas_cnt <= meas_cnt + 1'b1;
    end

    // Time since the last trigger, for the self-trigger
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i || trigger)
            trig_cnt <= '0;
        else if (trig_cnt != MEAS_W'(RETRIG_CYC - 1))
            trig_cnt <= trig_cnt + 1'b1;
    end

    // Completed result; held until the next completion
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            res_pos_o    <= '0;
            res_valid_o  <= 1'b0;
            meas_start_o <= 1'b0;
        end
        else
        begin
            meas_start_o <= trigger;
            if (done)
            begin
                res_pos_o   <= sensor_pos_i;
                res_valid_o <= sensor_ok_i;                 // [RL10]
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_no_retrigger: assert property (                     // [RL11]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        busy && !done |=> !meas_start_o)
        else $error("measurement retriggered while busy");

    // Helper count of cycles since the trigger; a delay range this long
    // would be unrolled by the tools, so the check reads a counter
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i || trigger)
            meas_age <= '0;
        else if (busy)
            meas_age <= meas_age + 1'b1;
    end

    chk_meas_time: assert property (                        // [RL12]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        done |-> meas_age >= MEAS_W'(MEAS_LO_CYC - 1)
            && meas_age <= MEAS_W'(MEAS_HI_CYC - 1))
        else $error("measurement did not finish in its window");

    chk_meas_bound: assert property (                       // [RL12]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        busy |-> meas_age < MEAS_W'(MEAS_HI_CYC))
        else $error("measurement still running after its window");

    chk_auto_trig: assert property (                        // [RL13]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !busy && trig_cnt == MEAS_W'(RETRIG_CYC - 1) |=> meas_start_o)
        else $error("self trigger missing after timeout");

endmodule : spb_meas

// *** hw/spb_pkg.sv ***
/*
 * Shared constants, types and the check-word function of the serial
 * position slave.
 * Assumes a single 250 MHz system clock for every file that imports it.
 */
package spb_pkg;

    // ************************************************************
    // Clock and link timing
    // ************************************************************
    localparam int CLK_MHZ        = 250;
    localparam int LINK_TOUT_US   = 15;
    // Least time, so whole cycles (exact here)
    localparam int LINK_TOUT_CYC  = LINK_TOUT_US * CLK_MHZ;
    localparam int TOUT_W         = 12;
    localparam int MEAS_TIME_US   = 90;
    localparam int MEAS_CYC_DEF   = MEAS_TIME_US * CLK_MHZ;
    localparam int RETRIG_US      = 135;
    localparam int RETRIG_CYC_DEF = RETRIG_US * CLK_MHZ;
    localparam int MEAS_W         = 16;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int PROC_CLKS = 12;          // Processing time, MA periods
    localparam int POS_W     = 22;          // Position field
    localparam int RES_BITS  = 18;          // Sensor resolution
    localparam int DATA_W    = 24;          // Data area
    localparam int CRC_W     = 6;
    localparam int SCD_W     = DATA_W + CRC_W;
    localparam int FRAME_W   = SCD_W + 2;   // Start and status bits too
    localparam int CNT_W     = 6;
    localparam int VALID_BIT = 1;
    localparam int TURN_BIT  = 0;
    localparam logic [CRC_W-1:0] CRC_POLY = 6'h03;  // x^6 + x + 1
    localparam logic [CRC_W-1:0] CRC_INIT = 6'h00;
    localparam logic START_BIT   = 1'b1;
    localparam logic STATUS_BIT  = 1'b0;
    localparam logic TURN_FLAG   = 1'b1;
    localparam logic [POS_W-RES_BITS-1:0] POS_PAD = '0;

    typedef enum logic [1:0] {
        SPB_IDLE,
        SPB_PROC,
        SPB_SHIFT,
        SPB_TOUT
    } spb_link_state_t;

    // Check word over the data area, MSB first
    function automatic logic [CRC_W-1:0] spb_crc6(
        input logic [DATA_W-1:0] data
    );
        logic [CRC_W-1:0] c;
        logic             fb;
        c = CRC_INIT;
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
            fb = c[CRC_W-1] ^ data[i];
            c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
        end
        return c;
    endfunction : spb_crc6

endpackage : spb_pkg

// *** hw/spb_serial_position_slave.sv ***
/*
 * Unidirectional serial position slave: answers master clock frames
 * on MA with start, status, 24-bit data area and inverted check word.
 * Assumes MA arrives asynchronously from the host (sampled twice) and
 * the sensor core gives a live position on clk_sys_i.
 */
`timescale 1ns/100ps
// Operation
// RL1: The master clocks MA at 600 to 2000 kHz and MA idle for the 15 us timeout ends a frame.
// RL2: Data goes back only on SL and the return input is tied low, so two one-way lines suffice.
// RL3: The link is point to point with this encoder as the only slave, no chaining or addressing.
// RL4: Each frame returns the position and status of the measurement triggered by the frame before.
// RL5: The single-turn transfer is 30 bits long and the master expects that length.
// RL6: The slave waits twelve MA periods of processing time before its start bit.
// RL7: A 24-bit data area is followed by a 6-bit check word, polynomial 0x43, seed zero, inverted.
// RL8: The data area is sent MSB first as 22 position bits, then valid flag, then turn flag last.
// RL9: A position narrower than 22 bits is left aligned with zero low bits.
// RL10: The valid flag is one for a good position and zero on error; the turn flag is always one.
// RL11: A frame start triggers a new measurement unless one is already running.
// RL12: A measurement result is ready 90 to 95 us after it starts.
// RL13: Without frames the device triggers itself 135 to 145 us after the last trigger.
// RL14: After processing it sends ack low, start, zero status, data and check word, then low to timeout.
module spb_serial_position_slave
#(
    parameter int MEAS_CYC   = spb_pkg::MEAS_CYC_DEF,
    parameter int RETRIG_CYC = spb_pkg::RETRIG_CYC_DEF
)
(
    input  wire logic                         clk_sys_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         ma_i,
    output logic                              sl_o,
    input  wire logic [spb_pkg::RES_BITS-1:0] sensor_pos_i,
    input  wire logic                         sensor_ok_i,
    output logic                              meas_start_o,
    output logic                              frame_busy_o
);
    import spb_pkg::*;

    logic                     ma_s1;
    logic                     ma_s2;
    logic                     ma_d;
    logic                     ma_rise;
    logic                     ma_fall;
    spb_link_state_t          state;
    logic [CNT_W-1:0]         bit_cnt;
    logic [TOUT_W-1:0]        idle_cnt;
    logic                     tout_hit;
    logic [FRAME_W-1:0]       frame_word;
    logic [FRAME_W-1:0]       next_frame;
    logic [DATA_W-1:0]        data_area;
    logic                     frame_start;
    logic [RES_BITS-1:0]      res_pos;
    logic                     res_valid;

    // ************************************************************
    // MA synchroniser and edge detect
    // ************************************************************
    // Only the second stage and its delayed copy ma_d feed logic; first stage may go metastable
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            ma_s1 <= 1'b1;
            ma_s2 <= 1'b1;
            ma_d  <= 1'b1;
        end
        else
        begin
            ma_s1 <= ma_i;
            ma_s2 <= ma_s1;
            ma_d  <= ma_s2;
        end
    end

    assign ma_rise = ma_s2 && !ma_d;
    assign ma_fall = !ma_s2 && ma_d;

    // ************************************************************
    // Link timeout: MA high and quiet ends the frame
    // ************************************************************
    // Counting on our own clock, not MA, because MA stops between frames
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i || !ma_s2 || ma_rise)
            idle_cnt <= '0;
        else if (!tout_hit)
            idle_cnt <= idle_cnt + 1'b1;
    end

    assign tout_hit = idle_cnt == TOUT_W'(LINK_TOUT_CYC - 1);   // [RL1]
    assign frame_start = state == SPB_IDLE && ma_fall;

    // ************************************************************
    // Frame word: start, status, data area, inverted check word
    // ************************************************************
    // Snapshot the last completed result, so the frame carries the
    // previous measurement while the new one runs
    assign data_area  = {res_pos, POS_PAD,                      // [RL9]
                         res_valid, TURN_FLAG};           // [RL8] [RL10]
    assign next_frame = {START_BIT, STATUS_BIT, data_area,
                         ~spb_crc6(data_area)};                 // [RL7]

    // ************************************************************
    // Link state machine
    // ************************************************************
    // The slave moves SL on MA rising edges; the master samples later
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            state      <= SPB_IDLE;
            bit_cnt    <= '0;
            frame_word <= '0;
            sl_o       <= 1'b1;
        end
        else
        begin
            case (state)
            SPB_IDLE:
                if (frame_start)
                begin
                    state      <= SPB_PROC;
                    bit_cnt    <= '0;
                    frame_word <= next_frame;                   // [RL4]
                end
            SPB_PROC:
                if (tout_hit)
                begin
                    state <= SPB_IDLE;
                    sl_o  <= 1'b1;
                end
                else if (ma_rise)
                begin
                    sl_o    <= 1'b0;                            // [RL14]
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == CNT_W'(PROC_CLKS - 1))       // [RL6]
                    begin
                        state   <= SPB_SHIFT;
                        bit_cnt <= '0;
                    end
                end
            SPB_SHIFT:
                if (tout_hit)
                begin
                    state <= SPB_IDLE;
                    sl_o  <= 1'b1;
                end
                else if (ma_rise)
                begin
                    sl_o       <= frame_word[FRAME_W-1];        // [RL2]
                    frame_word <= {frame_word[FRAME_W-2:0], 1'b0};
                    bit_cnt    <= bit_cnt + 1'b1;
                    if (bit_cnt == CNT_W'(FRAME_W - 1))         // [RL5]
                        state <= SPB_TOUT;
                end
            SPB_TOUT:
                if (tout_hit)
                begin
                    state <= SPB_IDLE;
                    sl_o  <= 1'b1;
                end
                else if (ma_rise)
                    sl_o <= 1'b0;                               // [RL14]
            default:
            begin
                state <= SPB_IDLE;
                sl_o  <= 1'b1;
            end
            endcase
        end
    end

    // Only a single slave is ever addressed; there is no chain input
    assign frame_busy_o = state != SPB_IDLE;                    // [RL3]

    // ************************************************************
    // Measurement sequencer
    // ************************************************************
    spb_meas #(
        .MEAS_CYC   (MEAS_CYC),
        .RETRIG_CYC (RETRIG_CYC)
    ) u_meas (
        .clk_sys_i     (clk_sys_i),
        .reset_n_i     (reset_n_i),
        .frame_start_i (frame_start),                           // [RL11]
        .sensor_pos_i  (sensor_pos_i),
        .sensor_ok_i   (sensor_ok_i),
        .meas_start_o  (meas_start_o),
        .res_pos_o     (res_pos),
        .res_valid_o   (res_valid)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    chk_sl_idle_high: assert property (                         // [RL14]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == SPB_IDLE && $past(state) == SPB_IDLE |-> sl_o)
        else $error("SL not high while idle");

    chk_proc_length: assert property (                          // [RL6]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == SPB_PROC && ma_rise && bit_cnt == CNT_W'(PROC_CLKS - 1)
        |=> state == SPB_SHIFT && !sl_o)
        else $error("processing time not twelve periods");

    chk_start_bit: assert property (                            // [RL14]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == SPB_SHIFT && bit_cnt == '0 && ma_rise && !tout_hit
        |=> sl_o)
        else $error("start bit not sent first");

    chk_frame_length: assert property (                         // [RL5]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == SPB_SHIFT && ma_rise && !tout_hit
        && bit_cnt == CNT_W'(FRAME_W - 1) |=> state == SPB_TOUT)
        else $error("frame length wrong");

    chk_link_timeout: assert property (                         // [RL1]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state != SPB_IDLE && tout_hit |=> state == SPB_IDLE && sl_o)
        else $error("timeout did not end frame");

    chk_turn_flag: assert property (                            // [RL10]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_start |=> frame_word[CRC_W + TURN_BIT] == TURN_FLAG)
        else $error("turn flag not one");

    chk_left_align: assert property (                           // [RL9]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_start |=> frame_word[CRC_W+2 +: POS_W-RES_BITS] == POS_PAD)
        else $error("position pad bits not zero");

    chk_crc_inverted: assert property (                         // [RL7]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_start |=> frame_word[CRC_W-1:0]
            == ~spb_crc6(frame_word[CRC_W +: DATA_W]))
        else $error("check word wrong");

    chk_pipeline: assert property (                             // [RL4]
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_start |=> frame_word[CRC_W+VALID_BIT] == $past(res_valid))
        else $error("frame does not carry previous result");

endmodule : spb_serial_position_slave

// *** test/spb_master_model.sv ***
/*
 * Behavioural host master for the serial position link: clocks one
 * frame of MA periods and gathers the bits that come back on SL.
 * Assumes the bench calls run_frame and that SL is registered by the
 * slave on its own clock, the same clock that paces this model.
 */
`timescale 1ns/100ps
module spb_master_model
#(
    parameter int HALF_CLKS = 10   // Half of an 80 ns MA period
)
(
    input  wire logic clk_sys_i,
    input  wire logic sl_i,
    output logic      ma_o
);

    // ************************************************************
    // Frame engine
    // ************************************************************
    // MA stands high between frames; one master, one slave on the link
    initial ma_o = 1'b1;

    // One frame of 45 rises; each bit is taken just before the next
    // fall, so the slave has half a period to settle its output
    task automatic run_frame(output logic [44:0] bits);
        bits = '0;
        for (int k = 1; k <= 45; k++)
        begin
            repeat (HALF_CLKS) @(posedge clk_sys_i);
            #1;
            if (k > 1)
                bits[46-k] = sl_i;
            ma_o = 1'b0;
            repeat (HALF_CLKS) @(posedge clk_sys_i);
            #1;
            ma_o = 1'b1;
        end
        // Last bit after a full period; MA then idles high until the
        // slave's timeout closes the frame
        repeat (2 * HALF_CLKS) @(posedge clk_sys_i);
        #1;
        bits[0] = sl_i;
    endtask : run_frame

endmodule : spb_master_model

// *** test/spb_serial_position_slave_bench.sv ***
/*
 * Self-checking bench for the serial position slave: frames from a
 * master model, pipelined results, retrigger rules and link timeout.
 * Assumes default measurement counts, since the design's own checks
 * hold the full-length figures.
 */
`timescale 1ns/100ps
module spb_serial_position_slave_bench;
    import spb_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam logic [RES_BITS-1:0] POS_A = 18'h2a5c3;
    localparam logic [RES_BITS-1:0] POS_B = 18'h15a3d;

    logic                clk_sys    = 1'b0;
    logic                reset_n    = 1'b0;
    logic                ma;
    logic                sl;
    logic [RES_BITS-1:0] sensor_pos = 18'h00000;
    logic                sensor_ok  = 1'b0;
    logic                meas_start;
    logic                frame_busy;
    int                  cyc        = 0;
    int                  n_fail     = 0;
    int                  n_tests    = 0;
    int                  trig[$];

    spb_serial_position_slave
    #(
        .MEAS_CYC   (MEAS_CYC_DEF),
        .RETRIG_CYC (RETRIG_CYC_DEF)
    )
    u_dut
    (
        .clk_sys_i    (clk_sys),
        .reset_n_i    (reset_n),
        .ma_i         (ma),
        .sl_o         (sl),
        .sensor_pos_i (sensor_pos),
        .sensor_ok_i  (sensor_ok),
        .meas_start_o (meas_start),
        .frame_busy_o (frame_busy)
    );

    spb_master_model u_master
    (
        .clk_sys_i (clk_sys),
        .sl_i      (sl),
        .ma_o      (ma)
    );

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    // Cycle count and the cycle of every measurement trigger
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (meas_start === 1'b1)
            trig.push_back(cyc);
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input string what, input logic [44:0] exp,
                         input logic [44:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // Whole frame as the master sees it: ack zeros, start, status,
    // data area, inverted check word, then low until the timeout
    function automatic logic [44:0] exp_frame(
        input logic [RES_BITS-1:0] pos,
        input logic                ok
    );
        logic [23:0] d;
        logic [5:0]  c;
        logic        fb;
        d = {pos, 4'h0, ok, 1'b1};
        c = 6'h00;
        for (int i = 23; i >= 0; i--)
        begin
            fb = c[5] ^ d[i];
            c  = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
        end
        return {12'h000, 1'b1, 1'b0, d, ~c, 1'b0};
    endfunction : exp_frame

    // One frame, then the idle stretch up to and past the timeout
    task automatic do_frame(input string what,
                            input logic [RES_BITS-1:0] pos,
                            input logic ok, input int n_trig);
        logic [44:0] got;
        int          k;
        u_master.run_frame(got);
        check(what, exp_frame(pos, ok), got);
        check("trigger count", 45'(n_trig), 45'(trig.size()));
        // The frame must not close short of the least timeout
        repeat (LINK_TOUT_CYC - 200) @(posedge clk_sys);
        #1;
        check("held frame", 45'(2'b10), 45'({frame_busy, sl}));
        k = 0;
        while (frame_busy !== 1'b0 && k < 600)
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 600)
        begin
            n_fail++;
            conclude();
        end
        @(posedge clk_sys);
        #1;
        check("closed frame", 45'(2'b01), 45'({frame_busy, sl}));
    endtask : do_frame

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        @(posedge clk_sys);
        #1;
        check("idle line", 45'(2'b01), 45'({frame_busy, sl}));
        sensor_pos = POS_A;
        sensor_ok  = 1'b1;
        // Nothing measured yet: empty result, turn flag still one
        do_frame("frame a", '0, 1'b0, 1);
        // Let the first measurement finish within its longest time
        while (cyc < trig[0] + 95 * CLK_MHZ)
            @(posedge clk_sys);
        #1;
        sensor_pos = POS_B;
        sensor_ok  = 1'b0;
        do_frame("frame b", POS_A, 1'b1, 2);
        // Too soon after b: no new trigger, result still from a's
        do_frame("frame c", POS_A, 1'b1, 2);
        // No frames for a while: the device triggers itself
        while (trig.size() < 3 && cyc < trig[1] + 40000)
            @(posedge clk_sys);
        check("self trigger", 45'(1), 45'(trig.size() == 3 &&
              trig[2] - trig[1] >= RETRIG_US * CLK_MHZ &&
              trig[2] - trig[1] <= 145 * CLK_MHZ));
        if (trig.size() < 3)
            conclude();
        // Self measurement running: frame must not retrigger it, and
        // the bad sensor reading shows as a cleared valid flag
        do_frame("frame d", POS_B, 1'b0, 3);
        conclude();
    end

endmodule : spb_serial_position_slave_bench
